// *** rtl/dfps_top.sv ***
// Frequency word and phase offset selection with APB registers and a serial word port.
// Assumes a 200 MHz system clock, an APB3 master on that clock, and a host that
// drives the serial shift clock, data and framing pins.
`include "dfps_regs.svh"

// Function
// - Falling frame signal starts a new serial word
// - Frequency select picks the phase step word
// - Frequency choice from pin or control bit
// - Frequency select pin sampled on master rising edge
// - Coincident pin change may shift switch one cycle
// - Four phase offsets, selected one is applied
// - Phase choice from two pins or bits
// - Phase pins sampled on rising edge, keep stable
// - Serial bits captured on falling shift clock edge
// - Phase select encoding maps to offsets 0..3
// - Two 32-bit frequency words, zero picks first
module dfps_top #(
  parameter int ADDR_W = 8
) (
  // System clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // Serial word link
  input wire logic i_sclk,
  input wire logic i_serial_word_in,
  input wire logic i_word_frame_n,
  // Select pins
  input wire logic i_freq_word_choose,
  input wire logic i_phase_choose_lo,
  input wire logic i_phase_choose_hi,
  // Selected values toward the accumulator
  output logic [31:0] o_phase_step,
  output logic [11:0] o_phase_offset,
  output logic o_freq_sel,
  output logic [1:0] o_phase_sel
);

  // ==========================================================================
  // Storage
  dfps_pkg::dfps_freq_t freq_word_a_ff;
  dfps_pkg::dfps_freq_t freq_word_b_ff;
  dfps_pkg::dfps_phase_t phase_mem_ff [4];
  logic [2:0] ctrl_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic nxt_hit;
  logic wr_en;
  // Pin synchronisers
  logic fs_s1_ff;
  logic fs_s2_ff;
  dfps_pkg::dfps_psel_t ps_s1_ff;
  dfps_pkg::dfps_psel_t ps_s2_ff;
  logic nxt_fsel;
  dfps_pkg::dfps_psel_t nxt_psel;
  logic fsel_ff;
  dfps_pkg::dfps_psel_t psel_ff;
  dfps_pkg::dfps_freq_t step_ff;
  dfps_pkg::dfps_phase_t offset_ff;
  // Link domain
  logic [4:0] bit_cnt_ff;
  dfps_pkg::dfps_word_t shift_ff;
  dfps_pkg::dfps_word_t link_word_ff;
  logic link_tgl_ff;
  // System side of the word crossing
  logic tgl_s1_ff;
  logic tgl_s2_ff;
  logic tgl_s3_ff;
  logic word_evt;
  dfps_pkg::dfps_word_t ser_word_ff;
  logic [15:0] ser_count_ff;

  // ==========================================================================
  // APB access
  // A write takes effect only in the access cycle that completes.
  assign wr_en = i_psel && i_penable && pready_ff && i_pwrite;
  // Read decode; unmapped addresses read zero and flag an error
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    nxt_hit = 1'b1;
    case (i_paddr)
      `DFPS_OFS_FREQ_A: nxt_prdata = freq_word_a_ff;
      `DFPS_OFS_FREQ_B: nxt_prdata = freq_word_b_ff;
      `DFPS_OFS_PHASE0: nxt_prdata = {20'h00000, phase_mem_ff[0]};
      `DFPS_OFS_PHASE1: nxt_prdata = {20'h00000, phase_mem_ff[1]};
      `DFPS_OFS_PHASE2: nxt_prdata = {20'h00000, phase_mem_ff[2]};
      `DFPS_OFS_PHASE3: nxt_prdata = {20'h00000, phase_mem_ff[3]};
      `DFPS_OFS_CTRL: nxt_prdata = {29'h0000_0000, ctrl_ff};
      `DFPS_OFS_STATUS: nxt_prdata = {29'h0000_0000, psel_ff, fsel_ff};
      `DFPS_OFS_SER_WORD: nxt_prdata = {16'h0000, ser_word_ff};
      `DFPS_OFS_SER_COUNT: nxt_prdata = {16'h0000, ser_count_ff};
      default: nxt_hit = 1'b0;
    endcase
  end

  // Answer one cycle after setup: ready, data and error from flops
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= i_psel && !i_penable;
      prdata_ff <= (i_psel && !i_penable && !i_pwrite) ? nxt_prdata : 32'h0000_0000;
      pslverr_ff <= i_psel && !i_penable && !nxt_hit;
    end
  end

  // Frequency words, written by software
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      freq_word_a_ff <= `DFPS_RST_FREQ;
      freq_word_b_ff <= `DFPS_RST_FREQ;
    end else if (wr_en) begin
      if (i_paddr == `DFPS_OFS_FREQ_A) begin
        freq_word_a_ff <= i_pwdata;
      end
      if (i_paddr == `DFPS_OFS_FREQ_B) begin
        freq_word_b_ff <= i_pwdata;
      end
    end
  end

  // Four phase offsets, low 12 bits of each word
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int i = 0; i < 4; i++) begin
        phase_mem_ff[i] <= `DFPS_RST_PHASE;
      end
    end else if (wr_en) begin
      for (int i = 0; i < 4; i++) begin
        if (i_paddr == `DFPS_OFS_PHASE0 + 8'(4 * i)) begin
          phase_mem_ff[i] <= i_pwdata[11:0];
        end
      end
    end
  end

  // Internal select bits
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_ff <= `DFPS_RST_CTRL;
    end else if (wr_en && (i_paddr == `DFPS_OFS_CTRL)) begin
      ctrl_ff <= i_pwdata[2:0];
    end
  end

  // ==========================================================================
  // Select pins and selection
  // Pins pass two flops on the rising master edge; a change near the edge
  // lands one cycle early or late, which the host must avoid.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      fs_s1_ff <= 1'b0;
      fs_s2_ff <= 1'b0;
      ps_s1_ff <= 2'h0;
      ps_s2_ff <= 2'h0;
    end else begin
      fs_s1_ff <= i_freq_word_choose;
      fs_s2_ff <= fs_s1_ff;
      ps_s1_ff <= {i_phase_choose_hi, i_phase_choose_lo};
      ps_s2_ff <= ps_s1_ff;
    end
  end

  // Unused source is held low, so OR merges pin and bit
  always_comb begin
    nxt_fsel = fs_s2_ff | ctrl_ff[`DFPS_BIT_FSEL];
    nxt_psel = ps_s2_ff | ctrl_ff[`DFPS_BIT_PSEL_HI:`DFPS_BIT_PSEL_LO];
  end

  // Registered step and offset; the accumulator keeps its phase
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      fsel_ff <= 1'b0;
      psel_ff <= 2'h0;
      step_ff <= `DFPS_RST_FREQ;
      offset_ff <= `DFPS_RST_PHASE;
    end else begin
      fsel_ff <= nxt_fsel;
      psel_ff <= nxt_psel;
      step_ff <= nxt_fsel ? freq_word_b_ff : freq_word_a_ff;
      offset_ff <= phase_mem_ff[nxt_psel];
    end
  end

  // ==========================================================================
  // Serial link on the shift clock
  // Bit counter is cleared by the frame going high, since the shift clock
  // may stop between words.
  always_ff @(negedge i_sclk or posedge i_reset or posedge i_word_frame_n) begin
    if (i_reset || i_word_frame_n) begin
      bit_cnt_ff <= 5'h00;
    end else if (bit_cnt_ff != `DFPS_SER_BITS) begin
      bit_cnt_ff <= bit_cnt_ff + 5'h01;
    end
  end

  // Shift in MSB first; the finished word is held and a toggle marks it
  always_ff @(negedge i_sclk or posedge i_reset) begin
    if (i_reset) begin
      shift_ff <= `DFPS_RST_WORD;
      link_word_ff <= `DFPS_RST_WORD;
      link_tgl_ff <= 1'b0;
    end else if (!i_word_frame_n && (bit_cnt_ff != `DFPS_SER_BITS)) begin
      shift_ff <= {shift_ff[14:0], i_serial_word_in};
      if (bit_cnt_ff == (`DFPS_SER_BITS - 5'h01)) begin
        link_word_ff <= {shift_ff[14:0], i_serial_word_in};
        link_tgl_ff <= !link_tgl_ff;
      end
    end
  end

  // ==========================================================================
  // Word crossing into the system clock
  // Held word is stable for at least sixteen shift clocks after the toggle.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      tgl_s1_ff <= 1'b0;
      tgl_s2_ff <= 1'b0;
      tgl_s3_ff <= 1'b0;
    end else begin
      tgl_s1_ff <= link_tgl_ff;
      tgl_s2_ff <= tgl_s1_ff;
      tgl_s3_ff <= tgl_s2_ff;
    end
  end

  assign word_evt = tgl_s2_ff ^ tgl_s3_ff;
  // Last received word and count of words
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ser_word_ff <= `DFPS_RST_WORD;
      ser_count_ff <= 16'h0000;
    end else if (word_evt) begin
      ser_word_ff <= link_word_ff;
      ser_count_ff <= ser_count_ff + 16'h0001;
    end
  end

  // ==========================================================================
  // Outputs
  assign o_pready = pready_ff;
  assign o_prdata = prdata_ff;
  assign o_pslverr = pslverr_ff;
  assign o_phase_step = step_ff;
  assign o_phase_offset = offset_ff;
  assign o_freq_sel = fsel_ff;
  assign o_phase_sel = psel_ff;

  // ==========================================================================
  // Assertions
  property p_step_sel;
    @(posedge i_clk) disable iff (i_reset)
      1 |=> step_ff == ($past(nxt_fsel) ? $past(freq_word_b_ff) : $past(freq_word_a_ff));
  endproperty
  a_step_sel: assert property (p_step_sel) else $error("Wrong frequency word");
  property p_word_a_zero;
    @(posedge i_clk) disable iff (i_reset)
      (!fs_s2_ff && !ctrl_ff[0]) ##1 $stable(freq_word_a_ff) |-> step_ff == freq_word_a_ff;
  endproperty
  a_word_a_zero: assert property (p_word_a_zero) else $error("Zero not first word");
  property p_ctrl_fsel;
    @(posedge i_clk) disable iff (i_reset)
      ctrl_ff[0] |=> fsel_ff;
  endproperty
  a_ctrl_fsel: assert property (p_ctrl_fsel) else $error("Bit select ignored");
  property p_fpin_lat;
    @(posedge i_clk) disable iff (i_reset)
      (i_freq_word_choose && !ctrl_ff[0]) [*3] |=> fsel_ff;
  endproperty
  a_fpin_lat: assert property (p_fpin_lat) else $error("Pin select late");
  property p_fpin_low;
    @(posedge i_clk) disable iff (i_reset)
      (!i_freq_word_choose && !ctrl_ff[0]) [*3] |=> !fsel_ff;
  endproperty
  a_fpin_low: assert property (p_fpin_low) else $error("Pin low not seen");
  property p_ppin_lat;
    @(posedge i_clk) disable iff (i_reset)
      (i_phase_choose_hi && !i_phase_choose_lo && (ctrl_ff[2:1] == 2'h0)) [*3]
        |=> psel_ff == 2'h2;
  endproperty
  a_ppin_lat: assert property (p_ppin_lat) else $error("Phase pin select late");
  // Offset follows the {hi,lo} encoding of the select one edge earlier
  property p_offset;
    @(posedge i_clk) disable iff (i_reset)
      1 |=> offset_ff == ($past(nxt_psel[1])
        ? ($past(nxt_psel[0]) ? $past(phase_mem_ff[3]) : $past(phase_mem_ff[2]))
        : ($past(nxt_psel[0]) ? $past(phase_mem_ff[1]) : $past(phase_mem_ff[0])));
  endproperty
  a_offset: assert property (p_offset) else $error("Wrong phase offset");
  property p_ctrl_psel;
    @(posedge i_clk) disable iff (i_reset)
      ctrl_ff[2:1] == 2'h3 |=> psel_ff == 2'h3;
  endproperty
  a_ctrl_psel: assert property (p_ctrl_psel) else $error("Phase bits ignored");
  property p_bit_cnt;
    @(negedge i_sclk) disable iff (i_reset || i_word_frame_n)
      bit_cnt_ff <= `DFPS_SER_BITS;
  endproperty
  a_bit_cnt: assert property (p_bit_cnt) else $error("Bit count overrun");
  // Shift clock stops between words, so the toggle is seen at the next word's first edge
  property p_word_done;
    @(negedge i_sclk) disable iff (i_reset)
      (!i_word_frame_n && (bit_cnt_ff == (`DFPS_SER_BITS - 5'h01)))
        |=> $changed(link_tgl_ff);
  endproperty
  a_word_done: assert property (p_word_done) else $error("Word not marked");
  property p_apb_ready;
    @(posedge i_clk) disable iff (i_reset)
      (i_psel && !i_penable) |=> o_pready ##1 !o_pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("APB ready timing");

  // Main scenarios
  c_word_b: cover property (@(posedge i_clk) disable iff (i_reset) fsel_ff ##1 !fsel_ff);
  c_phase3: cover property (@(posedge i_clk) disable iff (i_reset) psel_ff == 2'h3);
  c_word_rx: cover property (@(posedge i_clk) disable iff (i_reset) word_evt);
  c_apb_err: cover property (@(posedge i_clk) disable iff (i_reset) o_pready && o_pslverr);

endmodule : dfps_top

// *** rtl/dfps_regs.svh ***
// Register offsets, field positions, reset values and counts for the select block.
// Assumes byte addressing on a 32-bit APB slave, one aligned word per register.
`ifndef DFPS_REGS_SVH
`define DFPS_REGS_SVH

// ==========================================================================
// Register byte offsets
`define DFPS_OFS_FREQ_A 8'h00
`define DFPS_OFS_FREQ_B 8'h04
`define DFPS_OFS_PHASE0 8'h08
`define DFPS_OFS_PHASE1 8'h0C
`define DFPS_OFS_PHASE2 8'h10
`define DFPS_OFS_PHASE3 8'h14
`define DFPS_OFS_CTRL 8'h18
`define DFPS_OFS_STATUS 8'h1C
`define DFPS_OFS_SER_WORD 8'h20
`define DFPS_OFS_SER_COUNT 8'h24

// ==========================================================================
// Field positions in control and status
`define DFPS_BIT_FSEL 0
`define DFPS_BIT_PSEL_LO 1
`define DFPS_BIT_PSEL_HI 2

// ==========================================================================
// Reset values and counts
`define DFPS_RST_FREQ 32'h0000_0000
`define DFPS_RST_PHASE 12'h000
`define DFPS_RST_CTRL 3'h0
`define DFPS_RST_WORD 16'h0000
`define DFPS_SER_BITS 5'h10

`endif

// *** rtl/dfps_pkg.sv ***
// Types shared by the frequency and phase select block.
// Assumes the constants header supplies all numeric values.
package dfps_pkg;

  // ==========================================================================
  // Selector types
  typedef logic [1:0] dfps_psel_t;
  typedef logic [11:0] dfps_phase_t;
  typedef logic [31:0] dfps_freq_t;
  typedef logic [15:0] dfps_word_t;

endpackage : dfps_pkg

// *** verification/dfps_host_model.sv ***
// Host model: drives the serial word link and the three select pins.
// Assumes the bench calls one task at a time and supplies the system clock.
module dfps_host_model (
  // System clock used to time pin changes
  input wire logic i_clk,
  // Serial word link
  output logic o_sclk,
  output logic o_serial_word_in,
  output logic o_word_frame_n,
  // Select pins
  output logic o_freq_word_choose,
  output logic o_phase_choose_lo,
  output logic o_phase_choose_hi
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // Idle levels: link clock parked high, frame high, pins low
  initial begin
    o_sclk = 1'b1;
    o_serial_word_in = 1'b0;
    o_word_frame_n = 1'b1;
    o_freq_word_choose = 1'b0;
    o_phase_choose_lo = 1'b0;
    o_phase_choose_hi = 1'b0;
  end

  // ==========================================================================
  // Sends n bits MSB first at a 32 ns link clock; n below 16 aborts the word
  task automatic send_bits(input logic [15:0] w, input int n);
    #3;
    o_word_frame_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      o_serial_word_in = w[15-i];
      #16 o_sclk = 1'b0;
      #16 o_sclk = 1'b1;
    end
    o_word_frame_n = 1'b1;
    // Released data line must not keep its last value
    o_serial_word_in = ~o_serial_word_in;
    #512;
  endtask : send_bits

  // Pins change just after a rising edge, settled long before the next one
  task automatic set_pins(input logic f, input logic lo, input logic hi);
    @(posedge i_clk);
    o_freq_word_choose <= f;
    o_phase_choose_lo <= lo;
    o_phase_choose_hi <= hi;
    @(negedge i_clk);
  endtask : set_pins
endmodule : dfps_host_model

// *** verification/dfps_top_test.sv ***
// Self-checking bench for the frequency and phase select block.
// Assumes the rtl files and the host model are compiled before it.
`include "dfps_regs.svh"
module dfps_top_test;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // Signals
  logic i_clk, i_reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, phase_step;
  logic [11:0] phase_offset;
  logic freq_sel, sclk, serial_word_in, frame_n, fpin, plo, phi;
  logic [1:0] phase_sel;
  int failures = 0;
  int checks_done = 0;
  logic [11:0] ph [4] = '{12'h123, 12'h456, 12'h789, 12'hABC};
  localparam logic [31:0] FA = 32'hA5A5_0001;
  localparam logic [31:0] FB = 32'h5A5A_F00E;

  // ==========================================================================
  // Design and host model
  dfps_top dfps_top_inst (.i_clk(i_clk), .i_reset(i_reset), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .i_sclk(sclk),
    .i_serial_word_in(serial_word_in), .i_word_frame_n(frame_n), .i_freq_word_choose(fpin),
    .i_phase_choose_lo(plo), .i_phase_choose_hi(phi), .o_phase_step(phase_step),
    .o_phase_offset(phase_offset), .o_freq_sel(freq_sel), .o_phase_sel(phase_sel));
  dfps_host_model dfps_host_model_inst (.i_clk(i_clk), .o_sclk(sclk),
    .o_serial_word_in(serial_word_in), .o_word_frame_n(frame_n), .o_freq_word_choose(fpin),
    .o_phase_choose_lo(plo), .o_phase_choose_hi(phi));

  // Clock of 5 ns
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_n(input int n);
    repeat (n) @(negedge i_clk);
  endtask : wait_n

  // One APB transfer; pready, read data and error are all taken at the rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge i_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, rd, er);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 32'h0, rd, er);
    check(rd, exp);
  endtask : rd_chk

  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    logic [31:0] rd;
    logic er;
    check(phase_step, 32'h0);
    for (int a = 0; a <= 'h24; a += 4) rd_chk(8'(a), 32'h0);
    wr(`DFPS_OFS_SER_WORD, 32'hFFFF_FFFF);
    rd_chk(`DFPS_OFS_SER_WORD, 32'h0);
    apb(1'b0, 8'h28, 32'h0, rd, er);
    check({31'h0, er}, 32'h1);
  endtask : t_regs

  task automatic t_freq();
    wr(`DFPS_OFS_FREQ_A, FA);
    wr(`DFPS_OFS_FREQ_B, FB);
    wait_n(2);
    check(phase_step, FA);
    wr(`DFPS_OFS_CTRL, 32'h1);
    wait_n(2);
    check(phase_step, FB);
    check({31'h0, freq_sel}, 32'h1);
    rd_chk(`DFPS_OFS_STATUS, 32'h1);
    wr(`DFPS_OFS_CTRL, 32'h0);
    wait_n(2);
    check(phase_step, FA);
  endtask : t_freq

  task automatic t_freq_pin();
    dfps_host_model_inst.set_pins(1'b1, 1'b0, 1'b0);
    wait_n(2);
    check(phase_step, FA);
    wait_n(1);
    check(phase_step, FB);
    dfps_host_model_inst.set_pins(1'b0, 1'b0, 1'b0);
    wait_n(3);
    check(phase_step, FA);
  endtask : t_freq_pin

  task automatic t_phase();
    for (int i = 0; i < 4; i++) begin
      wr(`DFPS_OFS_PHASE0 + 8'(4 * i), {20'hFFFFF, ph[i]});
      rd_chk(`DFPS_OFS_PHASE0 + 8'(4 * i), {20'h0, ph[i]});
    end
    for (int i = 0; i < 4; i++) begin
      wr(`DFPS_OFS_CTRL, {29'h0, i[1:0], 1'b0});
      wait_n(2);
      check({20'h0, phase_offset}, {20'h0, ph[i]});
      check({30'h0, phase_sel}, 32'(i));
    end
    wr(`DFPS_OFS_CTRL, 32'h0);
    for (int i = 0; i < 4; i++) begin
      dfps_host_model_inst.set_pins(1'b0, i[0], i[1]);
      wait_n(3);
      check({20'h0, phase_offset}, {20'h0, ph[i]});
    end
    dfps_host_model_inst.set_pins(1'b0, 1'b0, 1'b0);
  endtask : t_phase

  task automatic t_serial();
    dfps_host_model_inst.send_bits(16'hC35A, 16);
    wait_n(8);
    rd_chk(`DFPS_OFS_SER_WORD, 32'h0000_C35A);
    rd_chk(`DFPS_OFS_SER_COUNT, 32'h1);
    // Aborted word must leave no trace in the next one
    dfps_host_model_inst.send_bits(16'hFFFF, 9);
    dfps_host_model_inst.send_bits(16'h0F1E, 16);
    wait_n(8);
    rd_chk(`DFPS_OFS_SER_WORD, 32'h0000_0F1E);
    rd_chk(`DFPS_OFS_SER_COUNT, 32'h2);
  endtask : t_serial

  // ==========================================================================
  // Verdict and end of run
  task automatic close_out();
    if (failures == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  // Watchdog
  initial begin
    #100000;
    failures++;
    close_out();
  end

  // Main sequence
  initial begin
    i_reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    t_regs();
    t_freq();
    t_freq_pin();
    t_phase();
    t_serial();
    close_out();
  end
endmodule : dfps_top_test
